// File: src/osc_defs.svh
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH
// register offsets (word addresses on the plain port)
`define OSC_ADDR_MODE 4'h0
`define OSC_ADDR_CTRL 4'h1
`define OSC_ADDR_STATUS 4'h2
`define OSC_ADDR_SELECT 4'h3
`define OSC_ADDR_IRQ_STAT 4'h4
`define OSC_ADDR_IRQ_MASK 4'h5
// field positions
`define OSC_MODE_SRC_BIT 1
`define OSC_CTRL_STOP_BIT 7
// settling flag count and select width
`define OSC_NUM_FLAGS 5
`define OSC_SEL_W 3
// reset values
`define OSC_SEL_RST 3'h4
`define OSC_DATA_RST 8'h00
// interrupt events: bit0 settle done, bit1 stop while cpu uses it
`define OSC_IRQ_DONE 0
`define OSC_IRQ_BADSTOP 1
`define OSC_NUM_IRQ 2
// settling thresholds as powers of two of oscillator cycles
`define OSC_THR_BASE 11
`endif

// File: src/osc_pkg.sv
package osc_pkg;
    typedef enum logic [1:0] {
        OSC_RUN = 2'b00,
        OSC_STOPPED = 2'b01,
        OSC_START = 2'b11,
        OSC_SETTLE = 2'b10
    } osc_state_t;
endpackage

// File: src/osc_cnt_if.sv
`timescale 1ns/1ps
interface osc_cnt_if;
    logic clear;
    logic count_en;
    logic [4:0] sel;
    logic [4:0] flags;
    logic reached;
    modport ctrl (output clear, output count_en, output sel, input flags, input reached);
    modport cnt (input clear, input count_en, input sel, output flags, output reached);
endinterface

// File: src/osc_settle_cnt.sv
`timescale 1ns/1ps
`include "osc_defs.svh"
module osc_settle_cnt import osc_pkg::*; #(
    parameter int NUM_FLAGS = `OSC_NUM_FLAGS,
    parameter int THR_BASE = `OSC_THR_BASE
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    // control from the state machine
    osc_cnt_if.cnt cnt
);
    localparam int CW = THR_BASE + NUM_FLAGS;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [NUM_FLAGS-1:0] flag_q, flag_d;
    logic [NUM_FLAGS-1:0] hit;

    ////////////////////////////////////////////////////////////////
    // one threshold per flag, shortest first
    genvar g;
    generate
        for (g = 0; g < NUM_FLAGS; g++) begin : g_thr
            assign hit[g] = cnt_q >= CW'(1) << (THR_BASE + g);
        end
    endgenerate

    // next values: counter holds once the selected threshold is passed
    always_comb begin
        cnt_d = cnt_q;
        flag_d = flag_q;
        if (cnt.clear) begin
            cnt_d = '0;
            flag_d = '0;
        end else if (cnt.count_en && !cnt.reached) begin
            cnt_d = cnt_q + CW'(1);
            flag_d = flag_q | (hit & cnt.sel);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            flag_q <= '0;
        end else if (en_i) begin
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign cnt.flags = flag_q;
    // reached when the longest selected flag is set
    assign cnt.reached = ((flag_q & cnt.sel) == cnt.sel);

    a_flags_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (en_i && !cnt.clear) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
        else $error("settling flag dropped without clear");
    a_flags_order: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ((flag_q >> 1) & ~flag_q) == '0)
        else $error("longer flag set before shorter");
    a_flags_in_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $stable(cnt.sel) |-> ((flag_q & ~cnt.sel) == '0 || $past(flag_q & ~cnt.sel) != '0))
        else $error("flag beyond selected time");
endmodule

// File: src/osc_regs.sv
`timescale 1ns/1ps
`include "osc_defs.svh"
module osc_regs import osc_pkg::*; #(
    parameter int NIRQ = `OSC_NUM_IRQ
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    // event inputs and read strobe for the status
    input wire logic [NIRQ-1:0] evt_i,
    input wire logic stat_rd_i,
    input wire logic mask_wr_i,
    input wire logic [NIRQ-1:0] mask_wdata_i,
    // state out
    output logic [NIRQ-1:0] stat_o,
    output logic [NIRQ-1:0] mask_o,
    output logic irq_o
);
    logic [NIRQ-1:0] stat_q, stat_d, mask_q, mask_d;

    // read clears, but a new event in the same cycle wins
    always_comb begin
        stat_d = (stat_rd_i ? '0 : stat_q) | evt_i;
        mask_d = mask_wr_i ? mask_wdata_i : mask_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            stat_q <= '0;
            mask_q <= '0;
        end else if (en_i) begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    assign stat_o = stat_q;
    assign mask_o = mask_q;
    assign irq_o = |(stat_q & mask_q);

    a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        irq_o == |(stat_o & mask_o))
        else $error("interrupt level mismatch");
    // an event in an enabled cycle is never lost, even against a clearing read
    a_evt_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (en_i && evt_i != '0) |=> (stat_q & $past(evt_i)) == $past(evt_i))
        else $error("event lost against status read");
endmodule

// File: src/osc_ctrl.sv
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "osc_defs.svh"
module osc_ctrl import osc_pkg::*; #(
    parameter int NUM_FLAGS = `OSC_NUM_FLAGS,
    parameter int THR_BASE = `OSC_THR_BASE
) (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // system events
    input wire logic stop_req_i,
    input wire logic stop_release_i,
    input wire logic osc_running_i,
    input wire logic rc_osc_opt_i,
    // status and control out
    output logic highspeed_osc_stop_o,
    output logic osc_stopped_o,
    output logic settle_done_o,
    output logic irq_o
);
    localparam int NIRQ = `OSC_NUM_IRQ;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by the second
    // stop and release come from the power controller, not from this clock
    logic [3:0] sync1_q, sync2_q;
    logic stop_req_s, release_s, running_s, rc_opt_s;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else if (clk_en_i) begin
            sync1_q <= {stop_req_i, stop_release_i, osc_running_i, rc_osc_opt_i};
            sync2_q <= sync1_q;
        end
    end
    assign {stop_req_s, release_s, running_s, rc_opt_s} = sync2_q;

    ////////////////////////////////////////////////////////////////
    // software registers
    logic cpu_clk_source_status_q, cpu_clk_source_status_d;
    logic highspeed_osc_stop_q, highspeed_osc_stop_d;
    logic [`OSC_SEL_W-1:0] settle_time_select_q, settle_time_select_d;
    logic [7:0] rdata_q, rdata_d;
    logic [NIRQ-1:0] irq_stat, irq_mask, evt;

    // decode used by both read and write paths
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    // select code to flag mask: code n keeps flags 0..n
    function automatic logic [NUM_FLAGS-1:0] sel_mask(input logic [`OSC_SEL_W-1:0] s);
        sel_mask = '0;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            if (i <= int'(s)) begin
                sel_mask[i] = 1'b1;
            end
        end
    endfunction

    always_comb begin
        cpu_clk_source_status_d = cpu_clk_source_status_q;
        highspeed_osc_stop_d = highspeed_osc_stop_q;
        settle_time_select_d = settle_time_select_q;
        if (wr_i && hit(addr_i, `OSC_ADDR_MODE)) begin
            cpu_clk_source_status_d = wdata_i[`OSC_MODE_SRC_BIT];
        end
        if (wr_i && hit(addr_i, `OSC_ADDR_CTRL)) begin
            highspeed_osc_stop_d = wdata_i[`OSC_CTRL_STOP_BIT];
        end
        if (wr_i && hit(addr_i, `OSC_ADDR_SELECT)) begin
            settle_time_select_d = wdata_i[`OSC_SEL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // stop / start state machine
    osc_state_t state_q, state_d;
    osc_cnt_if cif();
    logic [NUM_FLAGS-1:0] flags;

    always_comb begin
        state_d = state_q;
        cif.clear = 1'b0;
        cif.count_en = 1'b0;
        case (state_q)
            OSC_RUN: begin
                // stop_req must fall before release, or this re-enters stop at once
                if (stop_req_s) begin
                    cif.clear = 1'b1;
                    state_d = OSC_STOPPED;
                end
            end
            OSC_STOPPED: begin
                cif.clear = 1'b1;
                if (release_s) begin
                    state_d = OSC_START;
                end
            end
            OSC_START: begin
                if (running_s) begin
                    state_d = OSC_SETTLE;
                end
            end
            OSC_SETTLE: begin
                cif.count_en = 1'b1;
                // a new stop mid-settle drops the partial count, no credit kept
                if (stop_req_s) begin
                    cif.clear = 1'b1;
                    state_d = OSC_STOPPED;
                end else if (cif.reached || rc_opt_s) begin
                    state_d = OSC_RUN;
                end
            end
            default: begin
                state_d = OSC_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= OSC_RUN;
            cpu_clk_source_status_q <= 1'b0;
            highspeed_osc_stop_q <= 1'b0;
            settle_time_select_q <= `OSC_SEL_RST;
            rdata_q <= `OSC_DATA_RST;
        end else if (clk_en_i) begin
            state_q <= state_d;
            cpu_clk_source_status_q <= cpu_clk_source_status_d;
            highspeed_osc_stop_q <= highspeed_osc_stop_d;
            settle_time_select_q <= settle_time_select_d;
            rdata_q <= rdata_d;
        end
    end

    assign cif.sel = sel_mask(settle_time_select_q);

    osc_settle_cnt #(
        .NUM_FLAGS(NUM_FLAGS),
        .THR_BASE(THR_BASE)
    ) u_cnt (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i),
        .cnt(cif.cnt)
    );
    assign flags = cif.flags;

    ////////////////////////////////////////////////////////////////
    // interrupt events
    logic settling_q, settling_d;
    always_comb begin
        settling_d = (state_q == OSC_SETTLE);
        evt = '0;
        evt[`OSC_IRQ_DONE] = settling_q && (state_q == OSC_RUN);
        // reported, not blocked: keeping the source bit clear is software's duty
        evt[`OSC_IRQ_BADSTOP] = wr_i && hit(addr_i, `OSC_ADDR_CTRL)
            && wdata_i[`OSC_CTRL_STOP_BIT] && cpu_clk_source_status_q;
    end
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            settling_q <= 1'b0;
        end else if (clk_en_i) begin
            settling_q <= settling_d;
        end
    end

    osc_regs #(
        .NIRQ(NIRQ)
    ) u_regs (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en_i),
        .evt_i(evt),
        .stat_rd_i(rd_i && hit(addr_i, `OSC_ADDR_IRQ_STAT)),
        .mask_wr_i(wr_i && hit(addr_i, `OSC_ADDR_IRQ_MASK)),
        .mask_wdata_i(wdata_i[NIRQ-1:0]),
        .stat_o(irq_stat),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = `OSC_DATA_RST;
        if (rd_i) begin
            case (addr_i)
                `OSC_ADDR_MODE: rdata_d[`OSC_MODE_SRC_BIT] = cpu_clk_source_status_q;
                `OSC_ADDR_CTRL: rdata_d[`OSC_CTRL_STOP_BIT] = highspeed_osc_stop_q;
                `OSC_ADDR_STATUS: rdata_d[NUM_FLAGS-1:0] = flags;
                `OSC_ADDR_SELECT: rdata_d[`OSC_SEL_W-1:0] = settle_time_select_q;
                `OSC_ADDR_IRQ_STAT: rdata_d[NIRQ-1:0] = irq_stat;
                `OSC_ADDR_IRQ_MASK: rdata_d[NIRQ-1:0] = irq_mask;
                default: rdata_d = `OSC_DATA_RST;
            endcase
        end
    end

    assign rdata_o = rdata_q;
    assign highspeed_osc_stop_o = highspeed_osc_stop_q;
    assign osc_stopped_o = (state_q == OSC_STOPPED) || (state_q == OSC_START);
    // rc option skips the wait
    // forced even while stopped: nothing to wait for with the rc oscillator
    assign settle_done_o = (state_q == OSC_RUN) || rc_opt_s;

    ////////////////////////////////////////////////////////////////
    // checks
    sequence s_released;
        state_q == OSC_STOPPED && release_s && clk_en_i;
    endsequence
    sequence s_no_osc;
        !running_s && clk_en_i;
    endsequence

    a_wait_no_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_released ##1 s_no_osc |=> flags == '0)
        else $error("counted before oscillation");
    a_stop_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == OSC_STOPPED && clk_en_i) |=> flags == '0)
        else $error("flags not cleared in stop");
    a_rc_no_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == OSC_SETTLE && rc_opt_s && !stop_req_s && clk_en_i) |=> state_q == OSC_RUN)
        else $error("rc option still waits");
    // run only after selected flags set
    a_run_after_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == OSC_SETTLE && !rc_opt_s && !stop_req_s && clk_en_i) ##1
        state_q == OSC_RUN |-> $past(cif.reached))
        else $error("left settling early");
    a_rdata_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!rd_i && clk_en_i) |=> rdata_o == `OSC_DATA_RST)
        else $error("read data outside read slot");

    ////////////////////////////////////////////////////////////////
    // state walk checks: each step of the stop and restart path
    sequence s_stop_seen;
        (state_q == OSC_RUN || state_q == OSC_SETTLE) && stop_req_s && clk_en_i;
    endsequence
    sequence s_osc_seen;
        state_q == OSC_START && running_s && clk_en_i;
    endsequence
    // settling ends: one enabled cycle in SETTLE, the next in RUN
    sequence s_settle_end;
        (state_q == OSC_SETTLE && clk_en_i) ##1 (state_q == OSC_RUN && clk_en_i);
    endsequence

    a_stop_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_stop_seen |=> state_q == OSC_STOPPED)
        else $error("stop request not taken");
    a_release_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_released |=> state_q == OSC_START)
        else $error("release not taken");
    a_start_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_q == OSC_START && !running_s && clk_en_i) |=> state_q == OSC_START)
        else $error("left start before oscillation");
    a_count_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_osc_seen |=> state_q == OSC_SETTLE)
        else $error("counting not restarted");
    // end of settling is reported as an event
    a_done_event: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_settle_end |=> irq_stat[`OSC_IRQ_DONE])
        else $error("settle end event lost");
    // a stop written while the cpu still runs on this clock is reported
    a_badstop_evt: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (clk_en_i && wr_i && hit(addr_i, `OSC_ADDR_CTRL) && wdata_i[`OSC_CTRL_STOP_BIT]
            && cpu_clk_source_status_q) |=> irq_stat[`OSC_IRQ_BADSTOP])
        else $error("bad stop event lost");
    // a low enable freezes the machine and the read data
    a_freeze_state: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !clk_en_i |=> $stable(state_q) && $stable(rdata_o))
        else $error("state moved with enable low");
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`include "osc_defs.svh"
module tb_top;
    localparam int THR = 3;
    // positions of the single-bit outputs in the out_chk snapshot
    localparam logic [1:0] O_STOP = 2'h0;
    localparam logic [1:0] O_STOPPED = 2'h1;
    localparam logic [1:0] O_DONE = 2'h2;
    localparam logic [1:0] O_IRQ = 2'h3;
    ////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic stop_req_i = 1'b0;
    logic stop_release_i = 1'b0;
    logic osc_running_i = 1'b1;
    logic rc_osc_opt_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] rdata_o;
    logic highspeed_osc_stop_o;
    logic osc_stopped_o;
    logic settle_done_o;
    logic irq_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [7:0] rd_val;
    logic [5:0] m;

    // 250 MHz
    always #2 ref_clk_i = ~ref_clk_i;

    // short thresholds keep each settle under a few hundred cycles
    osc_ctrl #(.THR_BASE(THR)) u_osc_ctrl (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .stop_req_i(stop_req_i),
        .stop_release_i(stop_release_i),
        .osc_running_i(osc_running_i),
        .rc_osc_opt_i(rc_osc_opt_i),
        .highspeed_osc_stop_o(highspeed_osc_stop_o),
        .osc_stopped_o(osc_stopped_o),
        .settle_done_o(settle_done_o),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////
    // shared tasks, all but check entered just after a rising edge
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // outputs are read mid-cycle, clear of the edge that launches them
    task automatic out_chk(input string what, input logic exp, input logic [1:0] sel);
        logic [3:0] seen;
        @(negedge ref_clk_i);
        seen = {irq_o, settle_done_o, osc_stopped_o, highspeed_osc_stop_o};
        check(what, {7'h00, exp}, {7'h00, seen[sel]});
        @(posedge ref_clk_i);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        // one idle edge, so a following write never lowers and raises wr_i at once
        @(posedge ref_clk_i);
    endtask

    // read data stand only in the cycle after the strobe: sample mid-cycle
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        d = rdata_o;
        @(posedge ref_clk_i);
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        reg_rd(a, rd_val);
        check(what, exp, rd_val);
    endtask

    // oscillator stops together with the stop request
    task automatic enter_stop();
        stop_req_i <= 1'b1;
        osc_running_i <= 1'b0;
        cycles(6);
        out_chk("stopped flag", 1'b1, O_STOPPED);
        rd_chk("flags in stop", `OSC_ADDR_STATUS, 8'h00);
    endtask

    // release, hold oscillation off a while, then poll flags until done
    task automatic release_settle(input logic [4:0] exp);
        logic [4:0] prev;
        logic [4:0] cur;
        int i;
        prev = 5'h00;
        stop_req_i <= 1'b0;
        cycles(4);
        stop_release_i <= 1'b1;
        cycles(2);
        stop_release_i <= 1'b0;
        cycles(40);
        rd_chk("flags before oscillation", `OSC_ADDR_STATUS, 8'h00);
        out_chk("waiting for oscillation", 1'b1, O_STOPPED);
        osc_running_i <= 1'b1;
        for (i = 0; i < 400 && settle_done_o !== 1'b1; i++) begin
            reg_rd(`OSC_ADDR_STATUS, rd_val);
            cur = rd_val[4:0];
            check("flags in order", 8'h00, {3'b000, cur & (cur + 5'h01)});
            check("flags sticky", {3'b000, prev}, {3'b000, prev & cur});
            prev = cur;
        end
        cycles(2);
        out_chk("settle done", 1'b1, O_DONE);
        out_chk("oscillator running", 1'b0, O_STOPPED);
        rd_chk("final flags", `OSC_ADDR_STATUS, {3'b000, exp});
        check("wanted time reached", {3'b000, exp}, {3'b000, rd_val[4:0] & exp});
        cycles(300);
        rd_chk("flags after hold", `OSC_ADDR_STATUS, {3'b000, exp});
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cycles(8);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        out_chk("settle done at reset", 1'b1, O_DONE);
        out_chk("irq at reset", 1'b0, O_IRQ);
        out_chk("stop at reset", 1'b0, O_STOP);
        out_chk("stopped at reset", 1'b0, O_STOPPED);
        rd_chk("select reset", `OSC_ADDR_SELECT, 8'h04);
        rd_chk("ctrl reset", `OSC_ADDR_CTRL, 8'h00);
        rd_chk("mask reset", `OSC_ADDR_IRQ_MASK, 8'h00);
        rd_chk("irq stat reset", `OSC_ADDR_IRQ_STAT, 8'h00);
        rd_chk("unmapped read", 4'hf, 8'h00);
        // a write with the enable low must not be taken
        clk_en_i <= 1'b0;
        reg_wr(`OSC_ADDR_SELECT, 8'h02);
        clk_en_i <= 1'b1;
        rd_chk("select frozen", `OSC_ADDR_SELECT, 8'h04);
        $display("test reset finished");
        // select codes 0 to 5, the one past the last flag code meaning all flags
        for (int s = 0; s <= 5; s++) begin
            m = (6'h01 << (s + 1)) - 6'h01;
            reg_wr(`OSC_ADDR_SELECT, 8'(s));
            enter_stop();
            release_settle(m[4:0]);
            out_chk("masked irq", 1'b0, O_IRQ);
            rd_chk("done event", `OSC_ADDR_IRQ_STAT, 8'h01);
            rd_chk("event cleared", `OSC_ADDR_IRQ_STAT, 8'h00);
        end
        $display("test select codes finished");
        // unmasked done event raises the line until the status read
        reg_wr(`OSC_ADDR_SELECT, 8'h00);
        reg_wr(`OSC_ADDR_IRQ_MASK, 8'h03);
        enter_stop();
        release_settle(5'h01);
        out_chk("irq raised", 1'b1, O_IRQ);
        rd_chk("done event", `OSC_ADDR_IRQ_STAT, 8'h01);
        out_chk("irq cleared", 1'b0, O_IRQ);
        // stop while the cpu runs on this oscillator is flagged
        reg_wr(`OSC_ADDR_MODE, 8'h02);
        reg_wr(`OSC_ADDR_CTRL, 8'h80);
        cycles(2);
        out_chk("irq bad stop", 1'b1, O_IRQ);
        rd_chk("bad stop event", `OSC_ADDR_IRQ_STAT, 8'h02);
        reg_wr(`OSC_ADDR_MODE, 8'h00);
        reg_wr(`OSC_ADDR_CTRL, 8'h80);
        out_chk("stop output", 1'b1, O_STOP);
        rd_chk("ctrl readback", `OSC_ADDR_CTRL, 8'h80);
        rd_chk("no event", `OSC_ADDR_IRQ_STAT, 8'h00);
        reg_wr(`OSC_ADDR_CTRL, 8'h00);
        $display("test interrupts finished");
        // rc option: no wait needed even while stopped, so run it last
        enter_stop();
        rc_osc_opt_i <= 1'b1;
        cycles(6);
        out_chk("rc settle done", 1'b1, O_DONE);
        // release with the rc option: settling ends after one counting cycle
        release_settle(5'h00);
        rd_chk("rc done event", `OSC_ADDR_IRQ_STAT, 8'h01);
        $display("test rc option finished");
        end_sim();
    end

    // watchdog, several times the expected run length
    initial begin
        #100000;
        n_mismatch++;
        $display("unexpected timeout: expected end of tests, seen watchdog");
        end_sim();
    end
endmodule
